//--- inc/rsd_defs.vh
// constants for the dual synthesiser divider and lock control block
`ifndef RSD_DEFS_VH
`define RSD_DEFS_VH
`define RSD_ADDR_DATA 8'hB2
`define RSD_ADDR_CTRL 8'hB3
`define RSD_ADDR_STAT 8'hB4
`define RSD_N_W 20
`define RSD_R_W 13
`define RSD_WORD_W 16
`define RSD_STAT_W 8
`define RSD_CH_FLD_W 8
`define RSD_CB_EN 0
`define RSD_CB_SET 1
`define RSD_CB_TOL 2
`define RSD_CB_GAIN 3
`define RSD_CB_MASK 4
`define RSD_CB_LDSET 6
`define RSD_CB_REFSEL 7
`define RSD_CB_LDCH 14
`define RSD_TOL_ONE 3'h1
`define RSD_TOL_FOUR 3'h4
`define RSD_ERR_W 3
`define RSD_HIST_W 3
`define RSD_CTRL_RST 16'h0000
`define RSD_STAT_LOCK 0
`define RSD_STAT_LOST 2
`endif

//--- rtl/rsd_synth_ctrl.v
// dual integer-n synthesiser divider, set select and lock detect logic
`include "rsd_defs.vh"
module rsd_synth_ctrl (
    input wire sys_clk_in,
    input wire rst_in,
    input wire [7:0] reg_addr_in,
    input wire [15:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [15:0] reg_rdata_out,
    input wire xtal_ref_in,
    input wire synth_reference_clock_input,
    input wire [1:0] rf_fb_tick_in,
    output wire [1:0] pump_up_out,
    output wire [1:0] pump_down_out,
    output wire [1:0] pump_gain_out,
    output wire [1:0] lock_out,
    output wire irq_out
);
    reg [15:0] ctrl_q;
    reg [1:0] word_ptr_q;
    reg ref_prev_q;
    reg [1:0] lost_q;
    wire ref_level;
    wire ref_tick;
    wire wr_data;
    wire wr_ctrl;
    wire rd_stat;
    wire [1:0] lock_w;
    wire [1:0] lost_evt;
    wire [7:0] stat_w;

    assign wr_data = reg_wr_in && (reg_addr_in == `RSD_ADDR_DATA);
    assign wr_ctrl = reg_wr_in && (reg_addr_in == `RSD_ADDR_CTRL);
    assign rd_stat = reg_rd_in && (reg_addr_in == `RSD_ADDR_STAT);

    assign ref_level = ctrl_q[`RSD_CB_REFSEL] ? synth_reference_clock_input : xtal_ref_in;
    // edge found by sampling, so the reference must stay below half the clock rate
    assign ref_tick = ref_level && !ref_prev_q;

    always @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            ctrl_q <= `RSD_CTRL_RST;
            word_ptr_q <= 2'h0;
            ref_prev_q <= 1'b0;
        end
        else
        begin
            ref_prev_q <= ref_level;
            if (wr_ctrl)
            begin
                ctrl_q <= reg_wdata_in;
            end
            // four-word load sequence, pointer restarts on control write
            if (wr_ctrl)
                word_ptr_q <= 2'h0;
            else if (wr_data)
                word_ptr_q <= word_ptr_q + 2'h1;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1)
        begin : g_ch
            wire [7:0] cf;
            wire sel_rx;
            wire ld_here;
            wire [`RSD_N_W-1:0] n_act;
            wire [`RSD_R_W-1:0] r_act;
            wire ref_evt;
            wire fb_evt;
            wire [`RSD_ERR_W-1:0] tol;
            wire meas_done;
            wire in_tol;
            reg [`RSD_N_W-1:0] n_set_q [0:1];
            reg [`RSD_R_W-1:0] r_set_q [0:1];
            reg [`RSD_N_W-1:0] n_cnt_q;
            reg [`RSD_R_W-1:0] r_cnt_q;
            reg up_q;
            reg dn_q;
            reg [`RSD_ERR_W-1:0] err_q;
            reg [`RSD_HIST_W-1:0] hist_q;

            assign cf = ctrl_q[ch*`RSD_CH_FLD_W +: `RSD_CH_FLD_W];
            // swapping is a single control write
            assign sel_rx = cf[`RSD_CB_SET];
            assign n_act = n_set_q[sel_rx];
            assign r_act = r_set_q[sel_rx];
            assign ld_here = wr_data && (ctrl_q[`RSD_CB_LDCH] == ch);
            // gain bit drives pump current level
            assign pump_gain_out[ch] = cf[`RSD_CB_GAIN];

            // words write straight into the set, so halves are live
            // no interlock; host must avoid the active set
            always @(posedge sys_clk_in)
            begin
                if (rst_in)
                begin
                    n_set_q[0] <= {`RSD_N_W{1'b0}};
                    n_set_q[1] <= {`RSD_N_W{1'b0}};
                    r_set_q[0] <= {`RSD_R_W{1'b0}};
                    r_set_q[1] <= {`RSD_R_W{1'b0}};
                end
                else if (ld_here)
                begin
                    case (word_ptr_q)
                        2'h0: r_set_q[ctrl_q[`RSD_CB_LDSET]] <= reg_wdata_in[`RSD_R_W-1:0];
                        2'h1: n_set_q[ctrl_q[`RSD_CB_LDSET]][15:0] <= reg_wdata_in;
                        2'h2: n_set_q[ctrl_q[`RSD_CB_LDSET]][`RSD_N_W-1:16] <=
                            reg_wdata_in[`RSD_N_W-17:0];
                        default: ;
                    endcase
                end
            end

            // r sets comparison rate, n divides vco down to it
            assign ref_evt = ref_tick && (r_cnt_q >= r_act - {{(`RSD_R_W-1){1'b0}}, 1'b1});
            assign fb_evt = rf_fb_tick_in[ch] &&
                (n_cnt_q >= n_act - {{(`RSD_N_W-1){1'b0}}, 1'b1});
            assign tol = cf[`RSD_CB_TOL] ? `RSD_TOL_FOUR : `RSD_TOL_ONE;
            assign meas_done = (up_q || ref_evt) && (dn_q || fb_evt);
            assign in_tol = err_q <= tol;

            always @(posedge sys_clk_in)
            begin
                if (rst_in || !cf[`RSD_CB_EN])
                begin
                    r_cnt_q <= {`RSD_R_W{1'b0}};
                    n_cnt_q <= {`RSD_N_W{1'b0}};
                    up_q <= 1'b0;
                    dn_q <= 1'b0;
                    err_q <= {`RSD_ERR_W{1'b0}};
                    // relock after enable starts from an empty history
                    // disabled or reset reads unlocked
                    hist_q <= {`RSD_HIST_W{1'b0}};
                end
                else
                begin
                    if (ref_tick)
                        r_cnt_q <= ref_evt ? {`RSD_R_W{1'b0}} : r_cnt_q + 1'b1;
                    if (rf_fb_tick_in[ch])
                        n_cnt_q <= fb_evt ? {`RSD_N_W{1'b0}} : n_cnt_q + 1'b1;
                    if (meas_done)
                    begin
                        up_q <= 1'b0;
                        dn_q <= 1'b0;
                        err_q <= {`RSD_ERR_W{1'b0}};
                        hist_q <= {hist_q[1:0], in_tol};
                    end
                    else
                    begin
                        up_q <= up_q || ref_evt;
                        dn_q <= dn_q || fb_evt;
                        // saturate so a long gap never wraps back into tolerance
                        if ((up_q ^ dn_q) && ref_tick && (err_q != {`RSD_ERR_W{1'b1}}))
                            err_q <= err_q + 1'b1;
                    end
                end
            end

            assign pump_up_out[ch] = up_q;
            assign pump_down_out[ch] = dn_q;
            assign lock_w[ch] = (hist_q[0] & hist_q[1]) | (hist_q[1] & hist_q[2]) |
                (hist_q[0] & hist_q[2]);
        end
    endgenerate

    reg [1:0] lock_prev_q;
    assign lost_evt = lock_prev_q & ~lock_w;

    always @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            lock_prev_q <= 2'h0;
            lost_q <= 2'h0;
            reg_rdata_out <= 16'h0000;
        end
        else
        begin
            lock_prev_q <= lock_w;
            // disabling a locked channel also counts as a loss; mask first
            // a loss landing on the read clear still sticks
            lost_q <= (rd_stat ? 2'h0 : lost_q) | lost_evt;
            if (reg_rd_in)
                reg_rdata_out <= rd_stat ? {8'h00, stat_w} : 16'h0000;
        end
    end

    assign stat_w = {4'h0, lost_q, lock_w};
    assign lock_out = lock_w;
    assign irq_out = (lost_q[0] & ctrl_q[`RSD_CB_MASK]) |
        (lost_q[1] & ctrl_q[`RSD_CH_FLD_W + `RSD_CB_MASK]);
endmodule // rsd_synth_ctrl

//--- verif/rsd_chk_assertions.sv
// port assertions for the synthesiser control block
module rsd_chk (
    input wire sys_clk_in,
    input wire rst_in,
    input wire [7:0] reg_addr_in,
    input wire [15:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [15:0] reg_rdata_out,
    input wire [1:0] pump_up_out,
    input wire [1:0] pump_down_out,
    input wire [1:0] pump_gain_out,
    input wire [1:0] lock_out,
    input wire irq_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);
    wire ctl_wr = reg_wr_in && reg_addr_in == 8'hb3;
    wire st_rd = reg_rd_in && reg_addr_in == 8'hb4;
    wire [1:0] gain_wr = {reg_wdata_in[11], reg_wdata_in[3]};
    wire rd_hi_zero = reg_rdata_out[15:4] == 12'h000;
    wire [1:0] rd_lock = reg_rdata_out[1:0];
    wire mask_off_wr = ctl_wr && !reg_wdata_in[4] && !reg_wdata_in[12];
    a_reset_quiet: assert property ($fell(rst_in) |-> !irq_out && lock_out == 2'h0)
        else $error("outputs busy after reset");
    a_gain_load: assert property (ctl_wr |=> pump_gain_out == $past(gain_wr))
        else $error("gain bits not loaded");
    a_gain_hold: assert property (!ctl_wr |=> $stable(pump_gain_out))
        else $error("gain moved without write");
    a_other_read: assert property (reg_rd_in && !st_rd |=> reg_rdata_out == 16'h0000)
        else $error("non-status read not zero");
    a_stat_read: assert property (st_rd |=> rd_hi_zero && rd_lock == $past(lock_out))
        else $error("status read wrong");
    a_rdata_hold: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
        else $error("read data moved");
    a_lock_off: assert property (ctl_wr && !reg_wdata_in[0] |-> ##2 !lock_out[0])
        else $error("lock shown while disabled");
    a_irq_masked: assert property (mask_off_wr |-> ##2 !irq_out)
        else $error("irq despite mask");
    a_pump_exclusive: assert property ((pump_up_out & pump_down_out) == 2'h0)
        else $error("pump up and down together");
    cover property ($rose(lock_out[0]));
    cover property ($rose(irq_out));
    cover property (st_rd ##1 reg_rdata_out[2]);
endmodule // rsd_chk
bind rsd_synth_ctrl rsd_chk u_chk (.sys_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .pump_up_out, .pump_down_out, .pump_gain_out,
    .lock_out, .irq_out);

//--- verif/rsd_vco_model.sv
// crystal reference and vco feedback source, fixed 4-cycle periods
module rsd_vco_model (
    input wire logic sys_clk_in,
    output logic xtal_ref_out,
    output logic [1:0] fb_tick_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] ph_q = 2'h0;
    initial xtal_ref_out = 1'b0;
    initial fb_tick_out = 2'h0;
    // tick tied to reference phase
    // channel 1 gets no ticks, so it can never lock
    always @(posedge sys_clk_in)
    begin
        ph_q <= ph_q + 2'h1;
        xtal_ref_out <= ph_q[1];
        fb_tick_out <= {1'b0, ph_q == 2'h0};
    end
endmodule // rsd_vco_model

//--- verif/tb.sv
// self-checking bench for the synthesiser control block
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, xref, irq;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000, rdata;
    logic [1:0] fb, gain, lock, up, dn;
    // the one reference wave is steered to the crystal or the alternate pin
    logic xtal_on = 1'b1;
    int n_errors = 0, cmp_count = 0;
    initial forever #12.5 clk = ~clk;
    rsd_synth_ctrl dut (.sys_clk_in(clk), .rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .xtal_ref_in(xref & xtal_on),
        .synth_reference_clock_input(xref & !xtal_on), .rf_fb_tick_in(fb), .pump_up_out(up),
        .pump_down_out(dn), .pump_gain_out(gain), .lock_out(lock), .irq_out(irq));
    rsd_vco_model vco (.sys_clk_in(clk), .xtal_ref_out(xref), .fb_tick_out(fb));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        check(rdata, exp);
    endtask
    // control word, then r, n low, n high, spare
    task automatic load(input logic [15:0] ctl, input logic [12:0] r, input logic [19:0] n);
        wr_reg(8'hb3, ctl);
        wr_reg(8'hb2, {3'h0, r});
        wr_reg(8'hb2, n[15:0]);
        wr_reg(8'hb2, {12'h000, n[19:16]});
        wr_reg(8'hb2, 16'h0000);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        #200us;
        n_errors++;
        report_and_stop;
    end
    initial
    begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        rd_chk(8'hb4, 16'h0000);
        rd_chk(8'hb2, 16'h0000);
        $display("reset test done");
        // sets loaded while disabled; rx ratio 3/2 cannot match the vco
        // 10 mhz reference over r of 50 gives a 200 khz comparison rate
        load(16'h0000, 13'h0032, 20'h0_0032);
        load(16'h0040, 13'h0032, 20'h0_004b);
        // enable, one-cycle tolerance, gain, loss irq enabled
        wr_reg(8'hb3, 16'h0019);
        check({14'h0, gain}, 16'h0001);
        repeat (800) if (lock[0] !== 1'b1) @(negedge clk);
        rd_chk(8'hb4, 16'h0001);
        $display("lock test done");
        // rx set, four-cycle tolerance, alternate reference; crystal then stops
        wr_reg(8'hb3, 16'h009f);
        xtal_on = 1'b0;
        repeat (4000) if (irq !== 1'b1) @(negedge clk);
        // mask the loss: the flag stays, the irq must drop
        wr_reg(8'hb3, 16'h008f);
        check({15'h0, irq}, 16'h0000);
        rd_chk(8'hb4, 16'h0004);
        rd_chk(8'hb4, 16'h0000);
        check({15'h0, irq}, 16'h0000);
        $display("set switch test done");
        wr_reg(8'hb3, 16'h0800);
        // disable takes one more edge to clear the history and pumps
        @(negedge clk);
        check({14'h0, gain, lock}, 16'h0008);
        check({12'h000, up, dn}, 16'h0000);
        $display("gain test done");
        report_and_stop;
    end
endmodule // tb
